// File: rtl/adcc_top.sv
// converter control top: pin sequencing, calibration, output stage, apb registers
// assumes an apb master on i_sys_clk and pins asynchronous to it
// Operation
// R1 - flag words beyond full scale
// R2 - power-down pin high tristates outputs
// R3 - receiver discards pipeline after wake
// R4 - finish running calibration before power-down
// R5 - power-down at power-up holds wait count
// R6 - ignore calibration requests while powered down
// R7 - data changes on strobe edge chosen
// R8 - power-up wait two to 24 or 30
// R9 - calibration indicator high while calibrating
// R10 - swing select sets drive current
// R11 - output words are offset binary
// R12 - span select chooses 800 or 600 mV
// R13 - coupling select chooses common mode source
// R14 - primary latency seven, delayed eight
// R15 - request low ten then high ten
// R16 - request high at power-up skips calibration
// R17 - synchronise control pins before use
// R18 - range flag aligned with its word
`timescale 1ns/1ps
module adcc_top #(
    parameter int unsigned P_WAIT_SHORT = adcc_pkg::WAIT_SHORT_CYC,
    parameter int unsigned P_WAIT_LONG = adcc_pkg::WAIT_LONG_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_sample_clk,
    input wire logic [adcc_pkg::SAMPLE_W-1:0] i_sample_value,
    input wire logic i_power_down_pin,
    input wire logic i_trim_request_pin,
    input wire logic i_trim_wait_select,
    input wire logic i_data_edge_select,
    input wire logic i_output_swing_select,
    input wire logic i_input_span_select,
    input wire logic i_coupling_mode_select,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [adcc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [adcc_pkg::DATA_W-1:0] i_pwdata,
    output logic [adcc_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq,
    output logic [adcc_pkg::CODE_W-1:0] o_data_a,
    output logic [adcc_pkg::CODE_W-1:0] o_data_b,
    output logic o_out_of_range,
    output logic o_output_strobe,
    output logic o_out_oe_n,
    output logic o_trim_active,
    output logic o_drive_3ma,
    output logic o_span_800,
    output logic o_cm_internal
);
    import adcc_pkg::*;

    // pin synchronisers: first stage feeds only the second
    logic [7:0] pin_s1_r; // first stage, pins
    logic [7:0] pin_s2_r; // second stage, safe to use
    logic [SAMPLE_W-1:0] smp_s1_r; // first stage, sample value
    logic [SAMPLE_W-1:0] smp_s2_r; // second stage, sample value
    logic sclk_d_r; // last synced sample clock
    logic tick; // falling sample clock edge seen

    // named views of the synchronised pins
    logic sclk_s, pd_s, req_s, wait_sel_s, edge_s, swing_s, span_s, cm_s;

    // sequencer
    adcc_state_type state_r; // sequencer state
    logic [WAIT_CNT_W-1:0] cnt_r; // wait or calibration cycle count
    logic first_r; // no sample edge seen since reset
    logic [WAIT_CNT_W-1:0] wait_last; // last count of the power-up wait
    logic out_off; // outputs held in high impedance

    // request qualifier
    logic [3:0] low_cnt_r; // low ticks, saturating
    logic [3:0] high_cnt_r; // high ticks after arming
    logic armed_r; // enough low cycles seen
    logic trim_go; // request qualified this tick

    // output stage
    logic phase_r; // demux phase, buses update while low

    // registers
    logic [TRIM_LEN_W-1:0] trim_len_r; // calibration length in sample cycles
    logic [INT_W-1:0] int_stat_r; // sticky event bits
    logic [INT_W-1:0] int_mask_r; // interrupt enables
    logic [INT_W-1:0] int_set; // events this cycle
    logic int_clr; // status read completes
    logic setup; // apb setup phase
    logic access; // apb access completes this cycle
    logic hit; // address maps to a register

    adcc_pipe_if pif ();

    // two flip-flops on every asynchronous input
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            smp_s1_r <= 10'h000;
            smp_s2_r <= 10'h000;
        end else begin
            pin_s1_r <= {i_sample_clk, i_power_down_pin, i_trim_request_pin,
                         i_trim_wait_select, i_data_edge_select,
                         i_output_swing_select, i_input_span_select,
                         i_coupling_mode_select}; // R17
            pin_s2_r <= pin_s1_r;
            smp_s1_r <= i_sample_value;
            smp_s2_r <= smp_s1_r;
        end
    end

    assign sclk_s = pin_s2_r[7];
    assign pd_s = pin_s2_r[6];
    assign req_s = pin_s2_r[5];
    assign wait_sel_s = pin_s2_r[4];
    assign edge_s = pin_s2_r[3];
    assign swing_s = pin_s2_r[2];
    assign span_s = pin_s2_r[1];
    assign cm_s = pin_s2_r[0];

    // sample clock edge finder on the synced level
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    assign tick = sclk_d_r & ~sclk_s;

    // pipeline feed: one coded word per falling sample edge
    assign pif.push = tick;
    assign pif.word_in = adcc_clip(smp_s2_r); // R11 R1

    adcc_pipe u_pipe (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .pif(pif)
    );

    // power-up wait length from its select pin
    assign wait_last = wait_sel_s ? WAIT_CNT_W'(P_WAIT_LONG - 1) :
                                    WAIT_CNT_W'(P_WAIT_SHORT - 1); // R8

    // tristate while down or held down in the power-up wait
    assign out_off = (state_r == st_down) || ((state_r == st_wait) && pd_s); // R2

    // request qualifier: ten low ticks arm, ten high ticks fire
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_cnt_r <= 4'h0;
            high_cnt_r <= 4'h0;
            armed_r <= 1'b0;
        end else if (tick) begin
            if (state_r == st_down || pd_s) begin
                // nothing seen while down may count later
                low_cnt_r <= 4'h0; // R6
                high_cnt_r <= 4'h0;
                armed_r <= 1'b0;
            end else if (!req_s) begin
                // counting low cycles, a high phase restarts
                high_cnt_r <= 4'h0;
                if (low_cnt_r != REQ_LOW_CYC) begin
                    low_cnt_r <= low_cnt_r + 4'h1;
                end
                if (low_cnt_r >= REQ_LOW_CYC - 4'h1) begin
                    armed_r <= 1'b1; // R15
                end
            end else begin
                // high after arming counts toward the start
                low_cnt_r <= 4'h0;
                if (armed_r) begin
                    if (trim_go) begin
                        high_cnt_r <= 4'h0;
                        armed_r <= 1'b0;
                    end else begin
                        high_cnt_r <= high_cnt_r + 4'h1;
                    end
                end else begin
                    high_cnt_r <= 4'h0;
                end
            end
        end
    end

    // tenth high tick after arming starts calibration
    assign trim_go = tick && armed_r && req_s && !pd_s && (state_r != st_down)
                     && (high_cnt_r == REQ_HIGH_CYC - 4'h1); // R15

    // sequencer: power-up wait, run, calibrate, powered down
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= st_wait;
            cnt_r <= '0;
            first_r <= 1'b1;
        end else if (tick) begin
            first_r <= 1'b0;
            case (state_r)
                st_wait: begin
                    if (first_r && req_s) begin
                        // request high at power-up: skip calibration
                        state_r <= st_run; // R16
                        cnt_r <= '0;
                    end else if (!pd_s) begin
                        // wait counts only while the pin is low
                        if (cnt_r == wait_last) begin
                            state_r <= st_trim; // R8
                            cnt_r <= '0;
                        end else begin
                            cnt_r <= cnt_r + 1'b1; // R5
                        end
                    end
                end
                st_run: begin
                    if (pd_s) begin
                        state_r <= st_down; // R2
                    end else if (trim_go) begin
                        state_r <= st_trim;
                        cnt_r <= '0;
                    end
                end
                st_trim: begin
                    // the whole sequence runs even with power-down raised
                    if (cnt_r == WAIT_CNT_W'(trim_len_r) - 1'b1 || trim_len_r == '0) begin
                        state_r <= pd_s ? st_down : st_run; // R4
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                st_down: begin
                    if (!pd_s) begin
                        state_r <= st_run;
                    end
                end
                default: begin
                    state_r <= st_wait;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // output stage: buses update every other tick
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_r <= 1'b0;
            o_data_a <= 8'h00;
            o_data_b <= 8'h00;
            o_out_of_range <= 1'b0;
            o_output_strobe <= 1'b0;
            o_out_oe_n <= 1'b1;
        end else if (tick) begin
            if (out_off) begin
                // outputs released, demux realigned for the wake
                phase_r <= 1'b0;
                o_data_a <= 8'h00;
                o_data_b <= 8'h00;
                o_out_of_range <= 1'b0;
                o_output_strobe <= 1'b0;
                o_out_oe_n <= 1'b1; // R2
            end else begin
                phase_r <= ~phase_r;
                o_out_oe_n <= 1'b0;
                if (!phase_r) begin
                    // new words with the selected strobe edge
                    o_data_a <= pif.word_a[7:0]; // R14
                    o_data_b <= pif.word_b[7:0]; // R14
                    o_out_of_range <= pif.word_a[8] | pif.word_b[8]; // R18 R1
                    o_output_strobe <= edge_s; // R7
                end else begin
                    // opposite strobe edge mid word
                    o_output_strobe <= ~edge_s; // R7
                end
            end
        end
    end

    // static mode outputs and calibration indicator
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_trim_active <= 1'b0;
            o_drive_3ma <= 1'b0;
            o_span_800 <= 1'b0;
            o_cm_internal <= 1'b1;
        end else begin
            o_trim_active <= (state_r == st_trim); // R9
            o_drive_3ma <= swing_s; // R10
            o_span_800 <= span_s; // R12
            o_cm_internal <= ~cm_s; // R13
        end
    end

    // event sources for the sticky status bits
    always_comb begin
        int_set = '0;
        if (tick) begin
            int_set[INT_TRIM_DONE] = (state_r == st_trim) &&
                (cnt_r == WAIT_CNT_W'(trim_len_r) - 1'b1 || trim_len_r == '0);
            int_set[INT_PD_ENTER] = (state_r == st_run) && pd_s;
            // pipeline words after this are stale until flushed
            int_set[INT_PD_EXIT] = (state_r == st_down) && !pd_s; // R3
            int_set[INT_OOR] = !out_off && !phase_r &&
                (pif.word_a[8] | pif.word_b[8]); // R1
        end
    end

    // apb phase decode
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable && o_pready;
    assign hit = (i_paddr == OFS_CTRL) || (i_paddr == OFS_STATUS) ||
                 (i_paddr == OFS_INT_STAT) || (i_paddr == OFS_INT_MASK);
    assign int_clr = access && !i_pwrite && (i_paddr == OFS_INT_STAT);

    // apb answer, prepared in the setup cycle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && !hit;
            if (setup && !i_pwrite) begin
                case (i_paddr)
                    OFS_CTRL: o_prdata <= 32'(trim_len_r);
                    OFS_STATUS: begin
                        o_prdata <= '0;
                        o_prdata[STAT_STATE_LSB +: 2] <= state_r;
                        o_prdata[STAT_TRIM_ACT] <= (state_r == st_trim);
                        o_prdata[STAT_OUT_OFF] <= out_off;
                        o_prdata[STAT_PINS_LSB +: 7] <= pin_s2_r[6:0];
                    end
                    OFS_INT_STAT: o_prdata <= 32'(int_stat_r | int_set);
                    OFS_INT_MASK: o_prdata <= 32'(int_mask_r);
                    default: o_prdata <= '0;
                endcase
            end else if (setup) begin
                o_prdata <= '0;
            end
        end
    end

    // writable registers
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            trim_len_r <= TRIM_LEN_RST;
            int_mask_r <= INT_MASK_RST;
        end else if (access && i_pwrite) begin
            if (i_paddr == OFS_CTRL) begin
                trim_len_r <= i_pwdata[CTRL_TRIM_LEN_LSB +: TRIM_LEN_W];
            end
            if (i_paddr == OFS_INT_MASK) begin
                int_mask_r <= i_pwdata[INT_W-1:0];
            end
        end
    end

    // sticky events: a read clears, a new event wins
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            int_stat_r <= '0;
        end else begin
            int_stat_r <= (int_stat_r & ~{INT_W{int_clr}}) | int_set;
        end
    end

    // level interrupt from unmasked sticky bits
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(int_stat_r & int_mask_r);
        end
    end
endmodule

// File: rtl/adcc_pkg.sv
// constants, types and helpers of the converter control block
// assumes a 50 MHz system clock and a plain sample clock input
package adcc_pkg;
    // apb register map, byte addresses
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_INT_STAT = 12'h008;
    localparam logic [11:0] OFS_INT_MASK = 12'h00C;
    // control register: calibration length in sample cycles
    localparam int CTRL_TRIM_LEN_LSB = 0;
    localparam int TRIM_LEN_W = 16;
    localparam logic [15:0] TRIM_LEN_RST = 16'h0400;
    // interrupt bit positions
    localparam int INT_W = 4;
    localparam int INT_TRIM_DONE = 0;
    localparam int INT_PD_ENTER = 1;
    localparam int INT_PD_EXIT = 2;
    localparam int INT_OOR = 3;
    localparam logic [3:0] INT_MASK_RST = 4'h0;
    // status register field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_TRIM_ACT = 2;
    localparam int STAT_OUT_OFF = 3;
    localparam int STAT_PINS_LSB = 4;
    // power-up wait exponents and counts in sample cycles
    localparam int WAIT_SHORT_EXP = 24;
    localparam int WAIT_LONG_EXP = 30;
    localparam int unsigned WAIT_SHORT_CYC = 2 ** WAIT_SHORT_EXP;
    localparam int unsigned WAIT_LONG_CYC = 2 ** WAIT_LONG_EXP;
    localparam int WAIT_CNT_W = 31;
    // request qualification: cycles low, then cycles high
    localparam logic [3:0] REQ_LOW_CYC = 4'hA;
    localparam logic [3:0] REQ_HIGH_CYC = 4'hA;
    // conversion pipeline
    localparam int CODE_W = 8;
    localparam int SAMPLE_W = 10;
    localparam int PIPE_DEPTH = 8;
    localparam int LAT_PRIMARY = 7;
    localparam int LAT_DELAYED = 8;

    // sequencer states
    typedef enum logic [1:0] {
        st_wait = 2'b00,
        st_run = 2'b01,
        st_trim = 2'b10,
        st_down = 2'b11
    } adcc_state_type;

    // clip a signed sample to an offset binary code with its range flag
    function automatic logic [8:0] adcc_clip(input logic signed [9:0] v);
        logic [8:0] r;
        r = 9'h000;
        if (v > 10'sd127) begin
            r = {1'b1, 8'hFF};
        end else if (v < -10'sd128) begin
            r = {1'b1, 8'h00};
        end else begin
            r = {1'b0, v[7:0] ^ 8'h80};
        end
        return r;
    endfunction
endpackage

// File: rtl/adcc_pipe_if.sv
// signals between the control top and the pipeline store
// assumes both ends share the system clock
`timescale 1ns/1ps
interface adcc_pipe_if;
    logic push; // one-cycle pulse, a new word enters
    logic [8:0] word_in; // {range flag, code}
    logic [8:0] word_a; // word seven samples old
    logic [8:0] word_b; // word eight samples old
    modport ctrl (output push, output word_in, input word_a, input word_b);
    modport store (input push, input word_in, output word_a, output word_b);
endinterface

// File: rtl/adcc_pipe.sv
// conversion pipeline store: a shift line of coded words
// assumes push arrives at most once per sample period
`timescale 1ns/1ps
module adcc_pipe (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    adcc_pipe_if.store pif
);
    import adcc_pkg::*;

    // stage n holds the word pushed n+1 pushes ago
    logic [8:0] stage_r [0:PIPE_DEPTH-1];

    // shift on each push
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                stage_r[i] <= 9'h000;
            end
        end else if (pif.push) begin
            stage_r[0] <= pif.word_in;
            for (int i = 1; i < PIPE_DEPTH; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    // read before the shift: stage 6 is seven pushes old at a push
    assign pif.word_a = stage_r[LAT_PRIMARY-1];
    assign pif.word_b = stage_r[LAT_DELAYED-1];
endmodule

// File: tb/adcc_top_assertions.sv
// checker for the converter control top, watching its ports only
// assumes a bind into adcc_top and the system clock
`timescale 1ns/1ps
module adcc_top_assertions (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_power_down_pin,
    input wire logic i_data_edge_select,
    input wire logic i_output_swing_select,
    input wire logic i_input_span_select,
    input wire logic i_coupling_mode_select,
    input wire logic [7:0] o_data_a,
    input wire logic [7:0] o_data_b,
    input wire logic o_out_of_range,
    input wire logic o_output_strobe,
    input wire logic o_out_oe_n,
    input wire logic o_trim_active,
    input wire logic o_drive_3ma,
    input wire logic o_span_800,
    input wire logic o_cm_internal
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    logic [2:0] pins; // mode pins, output order
    assign pins = {i_output_swing_select, i_input_span_select, !i_coupling_mode_select};
    // trim start; outputs driven two cycles
    sequence s_trim_start;
        $rose(o_trim_active);
    endsequence
    sequence s_driven;
        !o_out_oe_n && !$past(o_out_oe_n);
    endsequence
    a_mode_follow: assert property ($stable(pins) [*5] |->
        {o_drive_3ma, o_span_800, o_cm_internal} == pins) else $error("mode outputs lag pins");
    a_range_code: assert property (o_out_of_range |-> o_data_a inside {8'h00, 8'hFF} ||
        o_data_b inside {8'h00, 8'hFF}) else $error("bad range flag");
    a_down_quiet: assert property (o_out_oe_n |-> o_data_a == 8'h00 && o_data_b == 8'h00 &&
        !o_out_of_range) else $error("buses active off");
    a_wake_pin: assert property ($fell(o_out_oe_n) |-> !$past(i_power_down_pin, 2))
        else $error("woke with pin high");
    a_strobe_edge: assert property ($changed(o_data_a) and s_driven |->
        o_output_strobe == i_data_edge_select) else $error("wrong strobe edge");
    a_trim_hold: assert property (s_trim_start |=> o_trim_active [*8])
        else $error("trim flag dropped");
    a_trim_driven: assert property (o_trim_active && $past(o_trim_active) |-> !o_out_oe_n)
        else $error("off during trim");
    a_trim_quiet: assert property (o_out_oe_n && $past(o_out_oe_n) |-> !$rose(o_trim_active))
        else $error("trim while down");
endmodule
bind adcc_top adcc_top_assertions adcc_top_assertions_inst (.i_sys_clk, .i_nrst,
    .i_power_down_pin, .i_data_edge_select, .i_output_swing_select, .i_input_span_select,
    .i_coupling_mode_select, .o_data_a, .o_data_b, .o_out_of_range, .o_output_strobe,
    .o_out_oe_n, .o_trim_active, .o_drive_3ma, .o_span_800, .o_cm_internal);

// File: tb/adcc_capture_model.sv
// receiver model latching both output buses on the strobe
// assumes sampling on the system clock
`timescale 1ns/1ps
module adcc_capture_model (
    input wire logic i_sys_clk,
    input wire logic i_oe_n,
    input wire logic i_strobe,
    input wire logic i_edge_sel,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_oor,
    output logic [7:0] o_a,
    output logic [7:0] o_b,
    output logic o_oor,
    output int o_valid
);
    logic strobe_q; // strobe one cycle back
    int skip; // stale captures still to drop
    // latch on the strobe edge away from data change
    always_ff @(posedge i_sys_clk) begin
        strobe_q <= i_strobe;
        if (i_oe_n) begin
            skip <= 4;
            o_valid <= 0;
        end else if (i_strobe != strobe_q && i_strobe != i_edge_sel) begin
            if (skip > 0) begin
                skip <= skip - 1;
            end else begin
                o_a <= i_a;
                o_b <= i_b;
                o_oor <= i_oor;
                o_valid <= o_valid + 1;
            end
        end
    end
endmodule

// File: tb/tb_adcc_top.sv
// self-checking bench for the converter control top
// assumes the checker and capture model are compiled first
`timescale 1ns/1ps
module tb_adcc_top;
    import adcc_pkg::*;
    logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_sample_clk = 1'b0;
    logic [9:0] i_sample_value = 10'h000;
    logic i_power_down_pin = 1'b1, i_trim_request_pin = 1'b0, i_trim_wait_select = 1'b0;
    logic i_data_edge_select = 1'b0, i_output_swing_select = 1'b1;
    logic i_input_span_select = 1'b0, i_coupling_mode_select = 1'b1;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd_v;
    logic o_pready, o_pslverr, o_irq, o_out_of_range, o_output_strobe, o_out_oe_n;
    logic o_trim_active, o_drive_3ma, o_span_800, o_cm_internal, cap_oor;
    logic [7:0] o_data_a, o_data_b, cap_a, cap_b;
    int n_fail = 0, n_checks = 0, n, cap_n;
    logic [9:0] smp [6] = '{10'h0C8, 10'h338, 10'h000, 10'h3FF, 10'h07F, 10'h380};
    logic [8:0] exp_w [6] = '{9'h1FF, 9'h100, 9'h080, 9'h07F, 9'h0FF, 9'h000};
    // system clock
    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    // sample clock, unrelated in phase
    initial begin
        #7;
        forever #80 i_sample_clk = ~i_sample_clk;
    end
    adcc_top #(.P_WAIT_SHORT(20), .P_WAIT_LONG(40)) adcc_top_inst (
        .i_sys_clk, .i_nrst, .i_sample_clk, .i_sample_value, .i_power_down_pin,
        .i_trim_request_pin, .i_trim_wait_select, .i_data_edge_select, .i_output_swing_select,
        .i_input_span_select, .i_coupling_mode_select, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq, .o_data_a, .o_data_b,
        .o_out_of_range, .o_output_strobe, .o_out_oe_n, .o_trim_active, .o_drive_3ma,
        .o_span_800, .o_cm_internal);
    adcc_capture_model adcc_capture_model_inst (.i_sys_clk, .i_oe_n(o_out_oe_n),
        .i_strobe(o_output_strobe), .i_edge_sel(i_data_edge_select), .i_a(o_data_a),
        .i_b(o_data_b), .i_oor(o_out_of_range), .o_a(cap_a), .o_b(cap_b), .o_oor(cap_oor),
        .o_valid(cap_n));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // k rising sample clock edges, then a system edge
    task tk(input int k);
        repeat (k) @(posedge i_sample_clk);
        @(posedge i_sys_clk);
    endtask
    // wait for the trim flag, n counts ticks
    task wt(input logic lvl);
        n = 0;
        while (o_trim_active !== lvl && n < 60) begin
            tk(1);
            n++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            t++;
        end while (o_pready !== 1'b1 && t < 20);
        rd_v = o_prdata;
        chk("answer", {o_pready, o_pslverr}, {1'b1, a > OFS_INT_MASK});
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, e);
    endtask
    task rst;
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial begin
        rst();
        chk("oe_n", o_out_oe_n, 1);
        rd("ctrl_rst", OFS_CTRL, 32'h400);
        rd("mask_rst", OFS_INT_MASK, 32'h0);
        rd("unmapped", 12'h010, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h4);
        apb(1'b1, OFS_INT_MASK, 32'h1);
        rd("ctrl_rw", OFS_CTRL, 32'h4);
        tk(40);
        chk("held_wait", o_trim_active, 0);
        chk("modes", {o_drive_3ma, o_span_800, o_cm_internal}, 3'b100);
        i_power_down_pin <= 1'b0;
        wt(1'b1);
        chk("wait_short", n inside {[19:22]}, 1);
        wt(1'b0);
        chk("trim_len", n inside {[3:5]}, 1);
        chk("irq_set", o_irq, 1);
        apb(1'b0, OFS_INT_STAT, 32'h0);
        chk("stat_done", rd_v[0], 1);
        repeat (2) @(posedge i_sys_clk);
        chk("irq_clear", o_irq, 0);
        $display("test power_up done");
        for (int i = 0; i < 6; i++) begin
            i_sample_value <= smp[i];
            tk(12);
            chk("word", {cap_oor, cap_a, cap_b}, {exp_w[i], exp_w[i][7:0]});
        end
        $display("test codes done");
        i_power_down_pin <= 1'b1;
        tk(3);
        chk("down", {o_out_oe_n, o_data_a}, 9'h100);
        i_data_edge_select <= 1'b1;
        i_sample_value <= 10'h000;
        i_trim_request_pin <= 1'b1;
        tk(12);
        i_trim_request_pin <= 1'b0;
        tk(12);
        i_trim_request_pin <= 1'b1;
        tk(12);
        chk("down_req", o_trim_active, 0);
        i_power_down_pin <= 1'b0;
        tk(16);
        chk("wake", {o_out_oe_n, o_trim_active}, 0);
        chk("flushed", {cap_n > 0, cap_oor, cap_a}, 10'h280);
        $display("test power_down done");
        apb(1'b1, OFS_INT_MASK, 32'h0);
        apb(1'b0, OFS_INT_STAT, 32'h0);
        i_trim_request_pin <= 1'b0;
        tk(12);
        i_trim_request_pin <= 1'b1;
        wt(1'b1);
        chk("req_delay", n inside {[9:12]}, 1);
        i_power_down_pin <= 1'b1;
        tk(2);
        chk("trim_pd", {o_trim_active, o_out_oe_n}, 2'b10);
        wt(1'b0);
        tk(2);
        chk("down_after", {o_out_oe_n, o_irq}, 2'b10);
        apb(1'b0, OFS_INT_STAT, 32'h0);
        chk("stat_masked", rd_v[1:0], 2'b01);
        $display("test command done");
        i_power_down_pin <= 1'b0;
        i_trim_request_pin <= 1'b0;
        i_trim_wait_select <= 1'b1;
        rst();
        wt(1'b1);
        chk("wait_long", n inside {[39:42]}, 1);
        i_trim_request_pin <= 1'b1;
        rst();
        tk(50);
        chk("req_skip", o_trim_active, 0);
        $display("test resets done");
        test_done();
    end
    // cut a hang short
    initial begin
        repeat (30000) @(posedge i_sys_clk);
        n_fail++;
        test_done();
    end
endmodule
